// ### rtl/scpwm_top.sv
// Two standard PWM channels with two 8-bit period timers and a byte register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R01: Channel pin carries PWM with ten-bit duty.
// R02: Cleared control register forces output latch low.
// R03: Software clears port direction bit for output; this block has no direction bit and always drives PWM_OUT.
// R04: Period is limit plus one, four, prescale.
// R05: Timer equal limit clears on next increment.
// R06: Pin set each period start unless duty zero.
// R07: Period end copies duty into shadow latches.
// R08: Duty is low register over control bits 5:4.
// R09: Duty writes anytime, applied after period ends.
// R10: Shadow register read-only while in PWM mode.
// R11: Pin cleared when duty equals extended timer.
// R12: Duty beyond period keeps pin high throughout.
// R13: Postscaler never affects PWM period or frequency.
// R14: Software sets limit, duty, pin, timer, mode; the block has no pin direction setting, only the other four.
// R15: Prescaler divides by one, four or sixteen.
// R16: Waveform only while mode field selects PWM.
module scpwm_top import scpwm_pkg::*; (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    output logic [1:0] PWM_OUT,
    output logic [1:0] POST_TICK_OUT
);
    // Timer state, one entry per timer.
    logic [7:0] count_reg [SCPWM_NTMR]; // Timer count.
    logic [7:0] count_next [SCPWM_NTMR];
    logic [7:0] limit_reg [SCPWM_NTMR]; // Period limit.
    logic [7:0] limit_next [SCPWM_NTMR];
    logic [7:0] tctrl_reg [SCPWM_NTMR]; // Run, prescale and postscale control.
    logic [7:0] tctrl_next [SCPWM_NTMR];
    logic [5:0] sub_reg [SCPWM_NTMR]; // Clock cycles inside one increment.
    logic [5:0] sub_next [SCPWM_NTMR];
    logic [3:0] post_reg [SCPWM_NTMR]; // Postscale match counter.
    logic [3:0] post_next [SCPWM_NTMR];
    logic [1:0] post_pulse_reg, post_pulse_next; // Postscaled match pulses.
    logic [1:0] tick; // Timer increments on this edge.
    logic [1:0] period_start; // Timer wraps to zero on this edge.
    logic [9:0] ext_next [SCPWM_NTMR]; // Count extended by two fine bits, after this edge.
    // Channel staging registers.
    logic [7:0] low_reg [SCPWM_NCH]; // Staged upper duty bits.
    logic [7:0] low_next [SCPWM_NCH];
    logic [7:0] cctrl_reg [SCPWM_NCH]; // Channel control.
    logic [7:0] cctrl_next [SCPWM_NCH];
    logic [7:0] shadow [SCPWM_NCH]; // Shadow bytes read back from channels.
    logic [1:0] tsel_reg, tsel_next; // Timer chosen for each channel.
    logic [7:0] rdata_reg, rdata_next; // Read data, one cycle after the strobe.

    // Fine bits below the count: the quarter phase at divide one, else prescaler bits.
    function automatic logic [1:0] fine_bits(input logic [1:0] pre, input logic [5:0] sub);
        logic [1:0] f;
        f = sub[5:4];
        if (pre == PRE_DIV1) begin
            f = sub[1:0];
        end else if (pre == PRE_DIV4) begin
            f = sub[3:2];
        end
        return f;
    endfunction

    // Last sub-count of an increment for the chosen prescale.
    function automatic logic [5:0] sub_limit(input logic [1:0] pre);
        logic [5:0] m;
        m = SUB_MAX_DIV16;
        if (pre == PRE_DIV1) begin
            m = SUB_MAX_DIV1;
        end else if (pre == PRE_DIV4) begin
            m = SUB_MAX_DIV4;
        end
        return m;
    endfunction

    genvar t;
    generate
        for (t = 0; t < SCPWM_NTMR; t++) begin : g_tmr
            logic run; // Timer enabled.
            logic [1:0] pre; // Prescale select.
            logic wrap; // Count equals limit.
            assign run = tctrl_reg[t][TCTRL_RUN_BIT];
            assign pre = tctrl_reg[t][TCTRL_PRE_LSB +: 2];
            assign wrap = (count_reg[t] == limit_reg[t]);
            assign tick[t] = run && (sub_reg[t] == sub_limit(pre)); // R04 R15
            assign period_start[t] = tick[t] && wrap; // R05
            assign ext_next[t] = {count_next[t], fine_bits(pre, sub_next[t])}; // R11

            // Next values of the timer: prescaled count, wrap and register writes.
            always_comb begin
                count_next[t] = count_reg[t];
                limit_next[t] = limit_reg[t];
                tctrl_next[t] = tctrl_reg[t];
                sub_next[t] = sub_reg[t];
                post_next[t] = post_reg[t];
                post_pulse_next[t] = 1'b0;
                if (run) begin
                    // Four cycles per oscillator quarter sequence, times the prescale.
                    sub_next[t] = tick[t] ? SUB_ZERO : sub_reg[t] + 6'h01; // R04 R15
                end
                if (tick[t]) begin
                    // A count equal to the limit clears on this increment.
                    count_next[t] = wrap ? ZERO_BYTE : count_reg[t] + 8'h01; // R05
                end
                if (period_start[t]) begin
                    // Postscaler only paces its own pulse, never the period.
                    if (post_reg[t] == tctrl_reg[t][TCTRL_POST_LSB +: 4]) begin
                        post_next[t] = POST_ZERO; // R13
                        post_pulse_next[t] = 1'b1; // R13
                    end else begin
                        post_next[t] = post_reg[t] + 4'h1;
                    end
                end
                if (WR_IN && ADDR_IN == ADDR_TMR_COUNT[t]) begin
                    // Writing the count also restarts the prescaler.
                    count_next[t] = WDATA_IN;
                    sub_next[t] = SUB_ZERO;
                end
                if (WR_IN && ADDR_IN == ADDR_TMR_LIMIT[t]) begin
                    limit_next[t] = WDATA_IN;
                end
                if (WR_IN && ADDR_IN == ADDR_TMR_CTRL[t]) begin
                    tctrl_next[t] = WDATA_IN & TCTRL_MASK;
                end
            end

            // Timer registers.
            always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    count_reg[t] <= ZERO_BYTE;
                    limit_reg[t] <= LIMIT_RESET;
                    tctrl_reg[t] <= ZERO_BYTE;
                    sub_reg[t] <= SUB_ZERO;
                    post_reg[t] <= POST_ZERO;
                end else begin
                    count_reg[t] <= count_next[t];
                    limit_reg[t] <= limit_next[t];
                    tctrl_reg[t] <= tctrl_next[t];
                    sub_reg[t] <= sub_next[t];
                    post_reg[t] <= post_next[t];
                end
            end
        end

        for (t = 0; t < SCPWM_NCH; t++) begin : g_ch
            // Next values of the channel staging registers; writable at any time.
            always_comb begin
                low_next[t] = low_reg[t];
                cctrl_next[t] = cctrl_reg[t];
                if (WR_IN && ADDR_IN == ADDR_CH_LOW[t]) begin
                    low_next[t] = WDATA_IN; // R09
                end
                if (WR_IN && ADDR_IN == ADDR_CH_CTRL[t]) begin
                    cctrl_next[t] = WDATA_IN & CCTRL_MASK; // R09
                end
            end

            // Channel staging registers.
            always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    low_reg[t] <= ZERO_BYTE;
                    cctrl_reg[t] <= ZERO_BYTE;
                end else begin
                    low_reg[t] <= low_next[t];
                    cctrl_reg[t] <= cctrl_next[t];
                end
            end

            // The channel follows the timer its select bit names.
            scpwm_channel u_channel (
                .clk_in(CLK_IN),
                .arst_n_in(ARST_N_IN),
                .ctrl_in(cctrl_reg[t]),
                .duty_low_in(low_reg[t]),
                .shadow_wr_in(WR_IN && ADDR_IN == ADDR_CH_SHADOW[t]),
                .wdata_in(WDATA_IN),
                .start_in(period_start[tsel_reg[t]]),
                .ext_next_in(ext_next[tsel_reg[t]]),
                .shadow_out(shadow[t]),
                .pwm_out(PWM_OUT[t])
            );
        end
    endgenerate

    // Timer select register and the read multiplexer.
    always_comb begin
        tsel_next = tsel_reg;
        rdata_next = ZERO_BYTE;
        if (WR_IN && ADDR_IN == ADDR_TIMER_SEL) begin
            tsel_next = WDATA_IN[1:0] & TIMER_SEL_MASK;
        end
        if (RD_IN) begin
            // Unmapped addresses read as zero.
            if (ADDR_IN == ADDR_TIMER_SEL) begin
                rdata_next = {6'h00, tsel_reg};
            end
            for (int i = 0; i < SCPWM_NTMR; i++) begin
                if (ADDR_IN == ADDR_TMR_COUNT[i]) begin
                    rdata_next = count_reg[i];
                end
                if (ADDR_IN == ADDR_TMR_LIMIT[i]) begin
                    rdata_next = limit_reg[i];
                end
                if (ADDR_IN == ADDR_TMR_CTRL[i]) begin
                    rdata_next = tctrl_reg[i];
                end
            end
            for (int i = 0; i < SCPWM_NCH; i++) begin
                if (ADDR_IN == ADDR_CH_LOW[i]) begin
                    rdata_next = low_reg[i];
                end
                if (ADDR_IN == ADDR_CH_SHADOW[i]) begin
                    rdata_next = shadow[i];
                end
                if (ADDR_IN == ADDR_CH_CTRL[i]) begin
                    rdata_next = cctrl_reg[i];
                end
            end
        end
    end

    // Bus-side registers.
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            tsel_reg <= 2'h0;
            rdata_reg <= ZERO_BYTE;
            post_pulse_reg <= 2'h0;
        end else begin
            tsel_reg <= tsel_next;
            rdata_reg <= rdata_next;
            post_pulse_reg <= post_pulse_next;
        end
    end

    assign RDATA_OUT = rdata_reg;
    assign POST_TICK_OUT = post_pulse_reg;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    // Checks on timer A and the read port; timer B shares the same logic and has only its pulse cover.
    wrap_clears_a: assert property (period_start[0] && !WR_IN |=> count_reg[0] == ZERO_BYTE) // R05
        else $error("timer not cleared after limit match");
    count_steps_a: assert property (tick[0] && !period_start[0] && !WR_IN
        |=> count_reg[0] == $past(count_reg[0]) + 8'h01) // R04
        else $error("timer did not step by one");
    div1_spacing_a: assert property (tick[0] && tctrl_reg[0][1:0] == PRE_DIV1 && !WR_IN
        ##1 (!WR_IN)[*3] |=> tick[0]) // R04
        else $error("divide one increment not four cycles");
    div_bound_a: assert property (tctrl_reg[0][TCTRL_RUN_BIT] && !WR_IN
        |-> ##[0:63] (tick[0] || WR_IN)) // R15
        else $error("prescaler never reached an increment");
    post_only_wrap_a: assert property (POST_TICK_OUT[0] |-> $past(period_start[0])) // R13
        else $error("postscale pulse without period end");
    read_zero_a: assert property (!RD_IN |=> RDATA_OUT == ZERO_BYTE)
        else $error("read data outside read slot");
    period_c: cover property (period_start[0] ##[1:300] period_start[0]);
    post_c: cover property (POST_TICK_OUT[1]);
endmodule
`default_nettype wire

// ### pkg/scpwm_pkg.sv
// Shared constants for the two-channel standard PWM block and its two period timers.
`default_nettype none
package scpwm_pkg;
    // Register bus geometry.
    localparam int SCPWM_AW = 4;
    localparam int SCPWM_DW = 8;
    localparam int SCPWM_NCH = 2;
    localparam int SCPWM_NTMR = 2;
    // Register addresses, one byte register at each.
    localparam logic [3:0] ADDR_TMR_COUNT [SCPWM_NTMR] = '{4'h0, 4'h3};
    localparam logic [3:0] ADDR_TMR_LIMIT [SCPWM_NTMR] = '{4'h1, 4'h4};
    localparam logic [3:0] ADDR_TMR_CTRL [SCPWM_NTMR] = '{4'h2, 4'h5};
    localparam logic [3:0] ADDR_CH_LOW [SCPWM_NCH] = '{4'h6, 4'h9};
    localparam logic [3:0] ADDR_CH_SHADOW [SCPWM_NCH] = '{4'h7, 4'hA};
    localparam logic [3:0] ADDR_CH_CTRL [SCPWM_NCH] = '{4'h8, 4'hB};
    localparam logic [3:0] ADDR_TIMER_SEL = 4'hC;
    // Reset values.
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'hFF;
    // Timer control fields: bit 7 unimplemented, 6:3 postscale, 2 run, 1:0 prescale.
    localparam logic [7:0] TCTRL_MASK = 8'h7F;
    localparam int TCTRL_RUN_BIT = 2;
    localparam int TCTRL_PRE_LSB = 0;
    localparam int TCTRL_POST_LSB = 3;
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    // Channel control fields: bits 7:6 unimplemented, 5:4 duty low bits, 3:0 mode.
    localparam logic [7:0] CCTRL_MASK = 8'h3F;
    localparam int CCTRL_DCB_LSB = 4;
    localparam int CCTRL_MODE_HI_LSB = 2;
    localparam logic [1:0] MODE_HI_PWM = 2'h3;
    localparam logic [1:0] TIMER_SEL_MASK = 2'h3;
    // Time base: one timer increment is four oscillator periods times the prescale.
    localparam int OSC_PERIOD_NS = 50;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_PER_INC = 4;
    localparam int CYC_PER_OSC = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUB_W = 6;
    localparam logic [5:0] SUB_MAX_DIV1 = 6'(OSC_PER_INC * CYC_PER_OSC * 1 - 1);
    localparam logic [5:0] SUB_MAX_DIV4 = 6'(OSC_PER_INC * CYC_PER_OSC * 4 - 1);
    localparam logic [5:0] SUB_MAX_DIV16 = 6'(OSC_PER_INC * CYC_PER_OSC * 16 - 1);
    localparam logic [3:0] POST_ZERO = 4'h0;
    localparam logic [5:0] SUB_ZERO = 6'h00;
endpackage
`default_nettype wire

// ### rtl/scpwm_channel.sv
// One PWM channel: duty double-buffer, output latch and duty compare.
`timescale 1ns/100ps
`default_nettype none
module scpwm_channel import scpwm_pkg::*; (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] ctrl_in,
    input wire logic [7:0] duty_low_in,
    input wire logic shadow_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic start_in,
    input wire logic [9:0] ext_next_in,
    output logic [7:0] shadow_out,
    output logic pwm_out
);
    logic [7:0] shadow_reg, shadow_next; // Upper eight bits of the live duty value.
    logic [1:0] lsb_reg, lsb_next; // Hidden two-bit latch for the duty low bits.
    logic out_reg, out_next; // Channel output latch.
    logic pwm_mode; // High while the mode field selects PWM.
    logic [9:0] duty_live; // Duty value in use this period.
    logic [9:0] duty_new; // Duty value software has staged.

    assign pwm_mode = (ctrl_in[CCTRL_MODE_HI_LSB +: 2] == MODE_HI_PWM); // R16
    assign duty_live = {shadow_reg, lsb_reg};
    assign duty_new = {duty_low_in, ctrl_in[CCTRL_DCB_LSB +: 2]}; // R08
    assign shadow_out = shadow_reg;
    assign pwm_out = out_reg; // R01

    // Next values of the buffer and output latch.
    always_comb begin
        shadow_next = shadow_reg;
        lsb_next = lsb_reg;
        out_next = out_reg;
        if (ctrl_in == ZERO_BYTE) begin
            // A cleared control register forces the latch low.
            out_next = 1'b0; // R02
            if (shadow_wr_in) begin
                shadow_next = wdata_in;
            end
        end else if (!pwm_mode) begin
            // Outside PWM mode the shadow is an ordinary writable byte.
            out_next = 1'b0; // R16
            if (shadow_wr_in) begin
                shadow_next = wdata_in;
            end
        end else if (start_in) begin
            // Period end: take the staged duty and raise the pin unless it is zero.
            shadow_next = duty_low_in; // R07 R09 R10
            lsb_next = ctrl_in[CCTRL_DCB_LSB +: 2]; // R07
            out_next = (duty_new != 10'h000); // R06
        end else if (duty_live == ext_next_in) begin
            // The extended count reaches the duty value: drop the pin.
            out_next = 1'b0; // R11 R12
        end
    end

    // Registers of the channel.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shadow_reg <= ZERO_BYTE;
            lsb_reg <= 2'h0;
            out_reg <= 1'b0;
        end else begin
            shadow_reg <= shadow_next;
            lsb_reg <= lsb_next;
            out_reg <= out_next;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // Checks on the channel behaviour.
    off_forces_low_a: assert property (ctrl_in == ZERO_BYTE |=> !pwm_out) // R02
        else $error("output not low after control cleared");
    start_sets_high_a: assert property (pwm_mode && start_in && duty_new != 10'h000 |=> pwm_out) // R06
        else $error("output not set at period start");
    zero_duty_low_a: assert property (pwm_mode && start_in && duty_new == 10'h000 |=> !pwm_out) // R06
        else $error("output set with zero duty");
    shadow_load_a: assert property (pwm_mode && start_in |=> duty_live == $past(duty_new)) // R07
        else $error("duty not latched at period end");
    duty_held_a: assert property (pwm_mode && !start_in |=> $stable(duty_live)) // R09
        else $error("duty changed inside a period");
    shadow_ro_a: assert property (pwm_mode && shadow_wr_in && !start_in |=> $stable(shadow_out)) // R10
        else $error("shadow written in pwm mode");
    match_clears_a: assert property (pwm_mode && !start_in && duty_live == ext_next_in |=> !pwm_out) // R11
        else $error("output not cleared on duty match");
    no_match_holds_a: assert property (pwm_mode && !start_in && duty_live != ext_next_in |=> $stable(pwm_out)) // R12
        else $error("output moved without match");
    not_pwm_low_a: assert property (ctrl_in != ZERO_BYTE && !pwm_mode |=> !pwm_out) // R16
        else $error("output active outside pwm mode");
    pulse_seen_c: cover property (pwm_mode && start_in && duty_new != 10'h000 ##[1:40] $fell(pwm_out));
    full_high_c: cover property (pwm_mode && start_in && pwm_out);
    zero_duty_c: cover property (pwm_mode && start_in && duty_new == 10'h000);
endmodule
`default_nettype wire

// ### test/scpwm_load.sv
// Model of the external load on one PWM pin: counts the cycles at which the pin is high.
`timescale 1ns/100ps
`default_nettype none
module scpwm_load (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic pwm_in,
    input wire logic clear_in,
    output logic [15:0] high_cnt_out
);
    // Count of high samples since the last clear.
    logic [15:0] high_cnt_reg;
    // Next value of that count.
    logic [15:0] high_cnt_next;
    // The pin is a plain driven output, so the load only samples its level.
    always_comb begin
        if (clear_in) begin
            high_cnt_next = 16'h0000;
        end else begin
            high_cnt_next = high_cnt_reg + 16'(pwm_in);
        end
    end
    // Registers the count; reset clears it.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            high_cnt_reg <= 16'h0000;
        end else begin
            high_cnt_reg <= high_cnt_next;
        end
    end
    assign high_cnt_out = high_cnt_reg;
endmodule
`default_nettype wire

// ### test/scpwm_top_test.sv
// Self-checking bench for the two-channel PWM block and its period timers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end
module scpwm_top_test import scpwm_pkg::*; ;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic [7:0] rdata;
    logic [1:0] pwm;
    logic [1:0] post_tick;
    logic [15:0] high_cnt [2];
    logic [7:0] post_cnt [2]; // Postscaled pulses of each timer since the last clear.
    int n_mismatch = 0;
    int check_count = 0;
    // Expected value of every address after reset, unmapped ones reading zero.
    logic [7:0] rst_val [16] = '{1: 8'hFF, 4: 8'hFF, default: 8'h00};
    // Duty values: zero, inside both periods, past timer a's period only, and beyond any period.
    logic [9:0] duty [4] = '{10'h000, 10'h006, 10'h009, 10'h3FF};
    // Free-running bench clock at 20 MHz.
    always #25 clk = ~clk;
    scpwm_top DUT (
        .CLK_IN(clk),
        .ARST_N_IN(arst_n),
        .ADDR_IN(addr),
        .WDATA_IN(wdata),
        .WR_IN(wr),
        .RD_IN(rd),
        .RDATA_OUT(rdata),
        .PWM_OUT(pwm),
        .POST_TICK_OUT(post_tick)
    );
    scpwm_load LOAD4 (.clk_in(clk), .arst_n_in(arst_n), .pwm_in(pwm[0]), .clear_in(clr), .high_cnt_out(high_cnt[0]));
    scpwm_load LOAD5 (.clk_in(clk), .arst_n_in(arst_n), .pwm_in(pwm[1]), .clear_in(clr), .high_cnt_out(high_cnt[1]));
    // Counts the postscaled period-end pulses over the same window as the loads.
    always_ff @(posedge clk) begin
        for (int t = 0; t < 2; t++) begin
            post_cnt[t] <= clr ? 8'h00 : post_cnt[t] + 8'(post_tick[t]);
        end
    end
    // One-cycle register write.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle register read; data are taken in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Clears both loads, then lets them count high cycles over a window of w cycles.
    task automatic measure(input int w, output logic [15:0] h4, output logic [15:0] h5);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (w) @(posedge clk);
        #1;
        h4 = high_cnt[0];
        h5 = high_cnt[1];
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    // Main sequence.
    initial begin
        logic [7:0] d;
        logic [15:0] h4;
        logic [15:0] h5;
        int pre;
        int e4;
        int e5;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values of the whole map, including the unmapped addresses.
        for (int i = 0; i < 16; i++) begin
            rd_reg(4'(i), d);
            `CHK(d, rst_val[i])
        end
        // Unimplemented bits read back as zero.
        wr_reg(ADDR_TMR_CTRL[0], 8'hFF);
        rd_reg(ADDR_TMR_CTRL[0], d);
        `CHK(d, 8'h7F)
        wr_reg(ADDR_CH_CTRL[0], 8'hFF);
        rd_reg(ADDR_CH_CTRL[0], d);
        `CHK(d, 8'h3F)
        wr_reg(ADDR_TIMER_SEL, 8'hFF);
        rd_reg(ADDR_TIMER_SEL, d);
        `CHK(d, 8'h03)
        wr_reg(ADDR_CH_CTRL[0], 8'h00);
        wr_reg(ADDR_TMR_CTRL[0], 8'h00);
        // Timer a ran briefly above; reloading its count restarts the prescaler from zero.
        wr_reg(ADDR_TMR_COUNT[0], 8'h00);
        // Channel four runs on timer a, channel five on timer b.
        wr_reg(ADDR_TIMER_SEL, 8'h02);
        wr_reg(ADDR_TMR_LIMIT[0], 8'h01);
        wr_reg(ADDR_TMR_LIMIT[1], 8'h03);
        // Every prescale against every duty, both channels at once.
        for (int p = 0; p < 3; p++) begin
            pre = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            for (int k = 0; k < 4; k++) begin
                wr_reg(ADDR_CH_LOW[0], duty[k][9:2]);
                wr_reg(ADDR_CH_LOW[1], duty[k][9:2]);
                wr_reg(ADDR_TMR_CTRL[0], {1'b0, POST_ZERO, 1'b1, 2'(p)});
                wr_reg(ADDR_TMR_CTRL[1], {1'b0, 4'hF, 1'b1, 2'(p)});
                wr_reg(ADDR_CH_CTRL[0], {2'h0, duty[k][1:0], 4'hC});
                wr_reg(ADDR_CH_CTRL[1], {2'h0, duty[k][1:0], 4'hC});
                repeat (32 * pre) @(posedge clk);
                measure(32 * pre, h4, h5);
                // High time is duty times prescale, or the whole period when duty exceeds it.
                e4 = (duty[k] >= 10'h008) ? 8 * pre : int'(duty[k]) * pre;
                e5 = (duty[k] >= 10'h010) ? 16 * pre : int'(duty[k]) * pre;
                `CHK(h4, 16'(4 * e4))
                `CHK(h5, 16'(2 * e5))
                // Postscale zero on timer a gives one pulse per period end, four in the window.
                `CHK(post_cnt[0], 8'h04)
            end
        end
        // New duty is staged, the shadow keeps the running value until the period ends.
        wr_reg(ADDR_TMR_COUNT[0], 8'h00);
        wr_reg(ADDR_CH_LOW[0], 8'h12);
        wr_reg(ADDR_CH_SHADOW[0], 8'h5A);
        rd_reg(ADDR_CH_SHADOW[0], d);
        `CHK(d, 8'hFF)
        repeat (300) @(posedge clk);
        rd_reg(ADDR_CH_SHADOW[0], d);
        `CHK(d, 8'h12)
        // A cleared control register and a non-PWM mode both keep the pin low.
        wr_reg(ADDR_CH_CTRL[1], 8'h38);
        wr_reg(ADDR_CH_CTRL[0], 8'h00);
        repeat (2) @(posedge clk);
        measure(4096, h4, h5);
        `CHK(h4, 16'h0000)
        `CHK(h5, 16'h0000)
        // Timers keep running: 32 periods of timer a, and one pulse per 16 periods of timer b.
        `CHK(post_cnt[0], 8'h20)
        `CHK(post_cnt[1], 8'h01)
        // Outside PWM mode the shadow takes writes.
        wr_reg(ADDR_CH_SHADOW[0], 8'h5A);
        rd_reg(ADDR_CH_SHADOW[0], d);
        `CHK(d, 8'h5A)
        test_done();
    end
endmodule
`default_nettype wire
